// ---- design/flux_supervisor.sv ----
// Fluxgate saturation supervisor: overload override, search, degauss, fault flags
//
// Overview of operation
// - Keep polarities of the four latest samples above the 13 uT threshold.
// - Check fluxgate saturation once every 4 us.
// - On saturation drive full scale with the sign of the last valid polarity.
// - When saturation ends, hand the bridge back to the analog loop.
// - Treat the 1.7 mT trip as saturation and hold the fault flag meanwhile; the code only raises the overrange flag, fault flag and bridge untouched.
// - Request held high 25 us starts a 500 ms degauss cycle.
// - Fault flag stays low for the whole degauss cycle.
// - Request high at power-up starts degauss at once.
// - Request low for more than 25 us aborts a running degauss.
// - Degauss first measures the offset, then drives a cancelling alternating wave.
// - Saturated at start-up means search instead of degauss, whatever the request.
// - First search phase: drive A to supply, B to ground, 30 ms.
// - Leaving saturation during search ends it and enters closed-loop running.
// - Still saturated after the first phase: swap polarity and repeat.
// - Still saturated 60 ms after search start: stay in fault with flag low.
// - Fault flag low for the first 80 us after power-up.
// - Fault flag low when the supply stays under 2.4 V beyond 20 us.
// - Release the fault flag once no fault remains and running resumed.
// - Fault flag is open-drain, active low, wired-OR capable.
// - Overrange flag is open-drain, active low, suppressed for 3 us.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fss_defs.svh"
module flux_supervisor #(
  parameter int                         DEGAUSS_CYC  = `FSS_DEGAUSS_CYC,
  parameter int                         SEARCH_CYC   = `FSS_SEARCH_PHASE_CYC,
  parameter int                         POWERUP_CYC  = `FSS_POWERUP_CYC,
  parameter int                         MEAS_SHIFT   = 16,
  parameter int                         HALF_CYC     = 1000,
  parameter logic [fss_pkg::FLUX_W-1:0] POL_THRESH   = 16'h0100,
  parameter logic [fss_pkg::FLUX_W-1:0] AMP_STEP     = 16'h0004
) (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              clkEn,
  input  wire logic signed [fss_pkg::FLUX_W-1:0] fluxSample,
  input  wire logic                              saturated,
  input  wire logic                              supplyLow,
  input  wire logic                              overrangeRaw,
  input  wire logic                              degauss_request,
  input  wire logic                              faultFlagIn,
  output logic                                   faultFlagOut,
  output logic                                   faultFlagOe,
  input  wire logic                              overrangeFlagIn,
  output logic                                   overrangeFlagOut,
  output logic                                   overrangeFlagOe,
  output fss_pkg::bridge_cmd_type                bridgeCmd,
  input  wire logic [31:0]                       awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [31:0]                       wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [31:0]                       araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [31:0]                            rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready
);
  localparam int W    = fss_pkg::FLUX_W;
  localparam int TW   = $clog2(DEGAUSS_CYC + 1);
  localparam int PW   = $clog2(POWERUP_CYC + 1);
  localparam int KW   = $clog2(`FSS_SAT_CHECK_CYC + 1);
  localparam int HW   = $clog2(HALF_CYC + 1);
  localparam int AW   = W + MEAS_SHIFT;

  initial begin
    if (SEARCH_CYC < 1 || DEGAUSS_CYC <= (1 << MEAS_SHIFT) || POWERUP_CYC < 1 || HALF_CYC < 1) begin
      $error("flux_supervisor: timing parameters out of range");
    end
    if (2 * SEARCH_CYC > DEGAUSS_CYC || MEAS_SHIFT > 24) begin
      $error("flux_supervisor: search time must fit the shared phase counter");
    end
  end

  typedef struct packed {
    fss_pkg::sup_state_type  st;
    logic [TW-1:0]           phaseCnt;
    logic [PW-1:0]           powerupCnt;
    logic                    powerupDone;
    logic [KW-1:0]           tickCnt;
    logic                    satSampled;
    logic                    armPrev;
    logic                    softDegauss;
    logic signed [AW-1:0]    offsetAcc;
    logic signed [W-1:0]     offset;
    logic [W-1:0]            amp;
    logic [HW-1:0]           halfCnt;
    logic                    wavePhase;
    fss_pkg::bridge_cmd_type bridge;
    logic                    faultOe;
    logic                    ovrOe;
    logic                    lineLow;
    logic                    awHeld;
    logic [31:0]             awAddr;
    logic                    wHeld;
    logic [31:0]             wData;
    logic [3:0]              wStrb;
    logic                    awReady;
    logic                    wReady;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    arReady;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
  } sup_reg_type;

  sup_reg_type s;
  sup_reg_type next_s;

  logic [3:0] history;
  logic       armReached;
  logic       abortReached;
  logic       brownout;
  logic       overrangeQual;
  logic       degaussLevel;

  // Request from the pin or from software
  assign degaussLevel = degauss_request | s.softDegauss;

  polarity_history #(
    .DEPTH (4)
  ) u_history (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .clkEn      (clkEn),
    .fluxSample (fluxSample),
    .threshold  (POL_THRESH),
    .saturated  (saturated),
    .history    (history)
  );

  persist_timer #(.COUNT(`FSS_DEGAUSS_ARM_CYC)) u_arm (
    .core_clk (core_clk), .sys_rst (sys_rst), .clkEn (clkEn),
    .level    (degaussLevel), .reached (armReached)
  );
  persist_timer #(.COUNT(`FSS_DEGAUSS_ABORT_CYC)) u_abort (
    .core_clk (core_clk), .sys_rst (sys_rst), .clkEn (clkEn),
    .level    (!degaussLevel), .reached (abortReached)
  );
  persist_timer #(.COUNT(`FSS_BROWNOUT_CYC)) u_brown (
    .core_clk (core_clk), .sys_rst (sys_rst), .clkEn (clkEn),
    .level    (supplyLow), .reached (brownout)
  );
  persist_timer #(.COUNT(`FSS_OVERRANGE_CYC)) u_ovr (
    .core_clk (core_clk), .sys_rst (sys_rst), .clkEn (clkEn),
    .level    (overrangeRaw), .reached (overrangeQual)
  );

  // Register index decode shared by the read and the write path
  function automatic logic [1:0] regSel(input logic [31:0] addr);
    case (addr)
      32'(`FSS_REG_CTRL):   regSel = 2'h1;
      32'(`FSS_REG_STATUS): regSel = 2'h2;
      32'(`FSS_REG_OFFSET): regSel = 2'h3;
      default:              regSel = 2'h0;
    endcase
  endfunction

  // Full-scale override value with the sign of the newest valid polarity
  function automatic logic signed [W-1:0] fullScale(input logic positive);
    fullScale = positive ? {1'b0, {(W-1){1'b1}}} : {1'b1, {(W-1){1'b0}}};
  endfunction

  // Supervisor sequencing, flags and register slave
  always_comb begin
    logic [31:0]        status;
    logic signed [W:0]  waveSum;
    next_s = s;
    status = '0;
    waveSum = '0;

    // Periodic saturation check, first sample taken at start-up
    if (s.tickCnt == KW'(`FSS_SAT_CHECK_CYC - 1) || s.st == fss_pkg::SUP_START) begin
      next_s.tickCnt    = '0;
      next_s.satSampled = saturated;
    end else begin
      next_s.tickCnt = s.tickCnt + 1'b1;
    end

    // Power-up blanking of the fault flag
    if (!s.powerupDone) begin
      next_s.powerupCnt = s.powerupCnt + 1'b1;
      if (s.powerupCnt == PW'(POWERUP_CYC - 1)) begin
        next_s.powerupDone = 1'b1;
      end
    end

    next_s.armPrev = armReached;
    next_s.phaseCnt = s.phaseCnt + 1'b1;

    case (s.st)
      fss_pkg::SUP_START: begin
        next_s.phaseCnt = '0;
        next_s.offsetAcc = '0;
        if (saturated) begin
          next_s.st = fss_pkg::SUP_SEARCH_A;
        end else if (degaussLevel) begin
          next_s.st = fss_pkg::SUP_DG_MEAS;
        end else begin
          next_s.st = fss_pkg::SUP_RUN;
        end
      end
      fss_pkg::SUP_RUN: begin
        next_s.phaseCnt = '0;
        next_s.offsetAcc = '0;
        if (s.satSampled) begin
          next_s.st = fss_pkg::SUP_OVERLOAD;
        end else if (armReached && !s.armPrev) begin
          next_s.st = fss_pkg::SUP_DG_MEAS;
        end
      end
      fss_pkg::SUP_OVERLOAD: begin
        if (!s.satSampled) begin
          next_s.st = fss_pkg::SUP_RUN;
        end
      end
      fss_pkg::SUP_SEARCH_A: begin
        if (!s.satSampled && s.phaseCnt != '0) begin
          next_s.st = fss_pkg::SUP_RUN;
        end else if (s.phaseCnt == TW'(SEARCH_CYC - 1)) begin
          next_s.st = fss_pkg::SUP_SEARCH_B;
          next_s.phaseCnt = '0;
        end
      end
      fss_pkg::SUP_SEARCH_B: begin
        if (!s.satSampled) begin
          next_s.st = fss_pkg::SUP_RUN;
        end else if (s.phaseCnt == TW'(SEARCH_CYC - 1)) begin
          next_s.st = fss_pkg::SUP_FAIL;
        end
      end
      fss_pkg::SUP_FAIL: begin
        next_s.phaseCnt = '0;
        if (!s.satSampled) begin
          next_s.st = fss_pkg::SUP_RUN;
        end
      end
      fss_pkg::SUP_DG_MEAS: begin
        next_s.offsetAcc = s.offsetAcc + AW'(fluxSample);
        if (abortReached) begin
          next_s.st = fss_pkg::SUP_RUN;
        end else if (s.phaseCnt == TW'((1 << MEAS_SHIFT) - 1)) begin
          next_s.st = fss_pkg::SUP_DG_WAVE;
          next_s.offset = W'(next_s.offsetAcc >>> MEAS_SHIFT);
          next_s.amp = {1'b0, {(W-1){1'b1}}};
          next_s.halfCnt = '0;
        end
      end
      fss_pkg::SUP_DG_WAVE: begin
        if (s.halfCnt == HW'(HALF_CYC - 1)) begin
          next_s.halfCnt = '0;
          next_s.wavePhase = !s.wavePhase;
          next_s.amp = (s.amp > AMP_STEP) ? s.amp - AMP_STEP : '0;
        end else begin
          next_s.halfCnt = s.halfCnt + 1'b1;
        end
        if (abortReached || s.phaseCnt == TW'(DEGAUSS_CYC - 1)) begin
          next_s.st = fss_pkg::SUP_RUN;
        end
      end
      default: begin
        next_s.st = fss_pkg::SUP_START;
      end
    endcase

    // Bridge command for the state being entered
    next_s.bridge.mode = fss_pkg::BR_LOOP;
    next_s.bridge.coilDriveA = 1'b0;
    next_s.bridge.coilDriveB = 1'b0;
    next_s.bridge.level = '0;
    case (next_s.st)
      fss_pkg::SUP_OVERLOAD: begin
        next_s.bridge.mode = fss_pkg::BR_OVERRIDE;
        next_s.bridge.level = fullScale(history[0]);
      end
      fss_pkg::SUP_SEARCH_A: begin
        next_s.bridge.mode = fss_pkg::BR_RAILS;
        next_s.bridge.coilDriveA = 1'b1;
      end
      fss_pkg::SUP_SEARCH_B: begin
        next_s.bridge.mode = fss_pkg::BR_RAILS;
        next_s.bridge.coilDriveB = 1'b1;
      end
      fss_pkg::SUP_DG_MEAS: begin
        next_s.bridge.mode = fss_pkg::BR_DEGAUSS;
      end
      fss_pkg::SUP_DG_WAVE: begin
        waveSum = (next_s.wavePhase ? -$signed({1'b0, next_s.amp}) : $signed({1'b0, next_s.amp}))
                  - (W+1)'(next_s.offset);
        next_s.bridge.mode = fss_pkg::BR_DEGAUSS;
        next_s.bridge.level = fss_pkg::clampLevel(waveSum);
      end
      default: begin
        next_s.bridge.mode = fss_pkg::BR_LOOP;
      end
    endcase

    // Fault flag pulls low in power-up, brownout or any state but run; overrange flag on qualified overrange
    next_s.faultOe = !next_s.powerupDone || brownout ||
                     (next_s.st != fss_pkg::SUP_RUN);
    next_s.ovrOe = overrangeQual;
    next_s.lineLow = 1'b0;

    status[`FSS_ST_STATE_LSB +: 8]  = s.st;
    status[`FSS_ST_SAT_BIT]         = s.satSampled;
    status[`FSS_ST_HIST_LSB +: 4]   = history;
    status[`FSS_ST_FAULT_BIT]       = s.faultOe;
    status[`FSS_ST_FAULTLINE_BIT]   = faultFlagIn;
    status[`FSS_ST_OVR_BIT]         = s.ovrOe;
    status[`FSS_ST_OVRLINE_BIT]     = overrangeFlagIn;

    // Write channel: address and data taken in either order
    if (awvalid && s.awReady) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    if (next_s.awHeld && next_s.wHeld && !next_s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = `FSS_RESP_OKAY;
      case (regSel(next_s.awAddr))
        2'h1: begin
          if (next_s.wStrb[0]) begin
            next_s.softDegauss = next_s.wData[`FSS_CTRL_DEGAUSS_BIT];
          end
        end
        2'h0: begin
          next_s.bResp = `FSS_RESP_DECERR;
        end
        default: begin
          next_s.bResp = `FSS_RESP_OKAY;
        end
      endcase
    end
    next_s.awReady = !next_s.awHeld && !next_s.bValid;
    next_s.wReady = !next_s.wHeld && !next_s.bValid;

    // Read channel: one cycle from address to data
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
    if (arvalid && s.arReady) begin
      next_s.rValid = 1'b1;
      next_s.rResp = `FSS_RESP_OKAY;
      case (regSel(araddr))
        2'h1: next_s.rData = {31'h0, s.softDegauss};
        2'h2: next_s.rData = status;
        2'h3: next_s.rData = 32'($signed(s.offset));
        default: begin
          next_s.rData = 32'h0;
          next_s.rResp = `FSS_RESP_DECERR;
        end
      endcase
    end
    next_s.arReady = !next_s.rValid;
  end

  // State register with reset value of the fault flag held asserted
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= fss_pkg::SUP_START;
      s.softDegauss <= `FSS_CTRL_RESET;
      s.faultOe <= 1'b1;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign faultFlagOut     = s.lineLow;
  assign faultFlagOe      = s.faultOe;
  assign overrangeFlagOut = s.lineLow;
  assign overrangeFlagOe  = s.ovrOe;
  assign bridgeCmd        = s.bridge;
  assign awready          = s.awReady;
  assign wready           = s.wReady;
  assign bresp            = s.bResp;
  assign bvalid           = s.bValid;
  assign arready          = s.arReady;
  assign rdata            = s.rData;
  assign rresp            = s.rResp;
  assign rvalid           = s.rValid;
endmodule

// ---- include/fss_defs.svh ----
// Offsets, field positions, reset values and timing counts of the saturation supervisor
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

`define FSS_CLK_PERIOD_NS     10
`define FSS_CEIL_CYC(ns)      (((ns) + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS)
`define FSS_FLOOR_CYC(ns)     ((ns) / `FSS_CLK_PERIOD_NS)

`define FSS_SAT_CHECK_NS      4000
`define FSS_SAT_CHECK_CYC     `FSS_FLOOR_CYC(`FSS_SAT_CHECK_NS)
`define FSS_DEGAUSS_ARM_NS    25000
`define FSS_DEGAUSS_ARM_CYC   `FSS_CEIL_CYC(`FSS_DEGAUSS_ARM_NS)
`define FSS_DEGAUSS_ABORT_NS  25000
`define FSS_DEGAUSS_ABORT_CYC (`FSS_CEIL_CYC(`FSS_DEGAUSS_ABORT_NS) + 1)
`define FSS_DEGAUSS_NS        500000000
`define FSS_DEGAUSS_CYC       `FSS_FLOOR_CYC(`FSS_DEGAUSS_NS)
`define FSS_SEARCH_PHASE_NS   30000000
`define FSS_SEARCH_PHASE_CYC  `FSS_FLOOR_CYC(`FSS_SEARCH_PHASE_NS)
`define FSS_POWERUP_NS        80000
`define FSS_POWERUP_CYC       `FSS_CEIL_CYC(`FSS_POWERUP_NS)
`define FSS_BROWNOUT_NS       20000
`define FSS_BROWNOUT_CYC      (`FSS_CEIL_CYC(`FSS_BROWNOUT_NS) + 1)
`define FSS_OVERRANGE_NS      3000
`define FSS_OVERRANGE_CYC     `FSS_CEIL_CYC(`FSS_OVERRANGE_NS)

`define FSS_REG_CTRL          8'h00
`define FSS_REG_STATUS        8'h04
`define FSS_REG_OFFSET        8'h08
`define FSS_CTRL_RESET        1'h0
`define FSS_CTRL_DEGAUSS_BIT  0
`define FSS_ST_STATE_LSB      0
`define FSS_ST_SAT_BIT        8
`define FSS_ST_HIST_LSB       9
`define FSS_ST_FAULT_BIT      13
`define FSS_ST_FAULTLINE_BIT  14
`define FSS_ST_OVR_BIT        15
`define FSS_ST_OVRLINE_BIT    16
`define FSS_RESP_OKAY         2'h0
`define FSS_RESP_DECERR       2'h3

`endif

// ---- include/fss_pkg.sv ----
// Types and helper functions of the saturation supervisor
package fss_pkg;

  parameter int FLUX_W = 16;

  typedef enum logic [7:0] {
    SUP_START     = 8'h01,
    SUP_RUN       = 8'h02,
    SUP_OVERLOAD  = 8'h04,
    SUP_SEARCH_A  = 8'h08,
    SUP_SEARCH_B  = 8'h10,
    SUP_FAIL      = 8'h20,
    SUP_DG_MEAS   = 8'h40,
    SUP_DG_WAVE   = 8'h80
  } sup_state_type;

  typedef enum logic [1:0] {
    BR_LOOP     = 2'h0,
    BR_OVERRIDE = 2'h1,
    BR_RAILS    = 2'h2,
    BR_DEGAUSS  = 2'h3
  } bridge_mode_type;

  typedef struct packed {
    bridge_mode_type           mode;
    logic                      coilDriveA;
    logic                      coilDriveB;
    logic signed [FLUX_W-1:0]  level;
  } bridge_cmd_type;

  // Magnitude of a signed sample, exact for the most negative code
  function automatic logic [FLUX_W-1:0] magnitude(input logic signed [FLUX_W-1:0] x);
    magnitude = x[FLUX_W-1] ? FLUX_W'(~x + 1'b1) : FLUX_W'(x);
  endfunction

  // Clamp a one-bit-wider value into the sample range
  function automatic logic signed [FLUX_W-1:0] clampLevel(input logic signed [FLUX_W:0] x);
    if (x[FLUX_W] != x[FLUX_W-1]) begin
      clampLevel = x[FLUX_W] ? {1'b1, {(FLUX_W-1){1'b0}}} : {1'b0, {(FLUX_W-1){1'b1}}};
    end else begin
      clampLevel = x[FLUX_W-1:0];
    end
  endfunction

endpackage

// ---- design/persist_timer.sv ----
// Qualifier that reports a level held high for a minimum number of cycles
`timescale 1ns/1ps
module persist_timer #(
  parameter int COUNT = 4
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic level,
  output logic      reached
);
  localparam int CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          reached;
  } pt_state_type;

  pt_state_type s;
  pt_state_type next_s;

  initial begin
    if (COUNT < 1) $error("persist_timer COUNT must be at least 1");
  end

  // Count while high, stop at the limit, clear on any low cycle
  always_comb begin
    next_s = s;
    if (!level) begin
      next_s.cnt     = '0;
      next_s.reached = 1'b0;
    end else if (s.cnt != CW'(COUNT)) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    next_s.reached = level && (next_s.cnt == CW'(COUNT));
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign reached = s.reached;
endmodule

// ---- design/polarity_history.sv ----
// Shift store of the polarities of the latest strong unsaturated fluxgate samples
`timescale 1ns/1ps
module polarity_history #(
  parameter int DEPTH = 4
) (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              clkEn,
  input  wire logic signed [fss_pkg::FLUX_W-1:0] fluxSample,
  input  wire logic [fss_pkg::FLUX_W-1:0]        threshold,
  input  wire logic                              saturated,
  output logic [DEPTH-1:0]                       history
);
  typedef struct packed {
    logic [DEPTH-1:0] hist;
  } ph_state_type;

  ph_state_type s;
  ph_state_type next_s;

  initial begin
    if (DEPTH < 2) $error("polarity_history DEPTH must be at least 2");
  end

  // Bit 0 holds the newest polarity, 1 meaning positive
  always_comb begin
    next_s = s;
    if (!saturated && fss_pkg::magnitude(fluxSample) > threshold) begin
      next_s.hist = {s.hist[DEPTH-2:0], ~fluxSample[fss_pkg::FLUX_W-1]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign history = s.hist;
endmodule

// ---- sim/fss_line_model.sv ----
// Pull-up model of the shared fault and overrange lines
`timescale 1ns/1ps
module fss_line_model (
  input  wire logic faultOe,
  input  wire logic ovrOe,
  output logic      faultLine,
  output logic      ovrLine
);
  // Either end pulling takes the wired line low, else the pull-up wins
  assign faultLine = !(faultOe || ovrOe);
  assign ovrLine   = !(faultOe || ovrOe);
endmodule

// ---- sim/flux_supervisor_props.sv ----
// Port assertions of the saturation supervisor
`timescale 1ns/1ps
module flux_supervisor_props (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    saturated,
  input wire logic                    degauss_request,
  input wire logic                    overrangeRaw,
  input wire logic                    faultFlagOut,
  input wire logic                    faultFlagOe,
  input wire logic                    overrangeFlagOut,
  input wire logic                    overrangeFlagOe,
  input wire fss_pkg::bridge_cmd_type bridgeCmd,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    rvalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Flag pins only ever pull low
  property p_open; faultFlagOut == 1'h0 && overrangeFlagOut == 1'h0; endproperty
  a_open: assert property (p_open) else $error("flag pin driven high");
  property p_ovl; bridgeCmd.mode == fss_pkg::BR_OVERRIDE |-> faultFlagOe; endproperty
  a_ovl: assert property (p_ovl) else $error("override without fault");
  property p_dgf; bridgeCmd.mode == fss_pkg::BR_DEGAUSS |-> faultFlagOe; endproperty
  a_dgf: assert property (p_dgf) else $error("degauss without fault");
  property p_rail; bridgeCmd.mode == fss_pkg::BR_RAILS |-> bridgeCmd.coilDriveA != bridgeCmd.coilDriveB && faultFlagOe; endproperty
  a_rail: assert property (p_rail) else $error("rails not opposite");
  property p_tick; $rose(bridgeCmd.mode == fss_pkg::BR_OVERRIDE) |-> $past(saturated, 2); endproperty
  a_tick: assert property (p_tick) else $error("override without saturation");
  property p_arm; $rose(bridgeCmd.mode == fss_pkg::BR_DEGAUSS) |-> $past(degauss_request, 8); endproperty
  a_arm: assert property (p_arm) else $error("degauss without request");
  property p_ovr; $rose(overrangeFlagOe) |-> $past(overrangeRaw, 8); endproperty
  a_ovr: assert property (p_ovr) else $error("overrange flag too early");
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr; awvalid && awready && wvalid && wready |=> bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
endmodule

// ---- sim/tb_flux_supervisor.sv ----
// Self-checking bench of the saturation supervisor
`timescale 1ns/1ps
module tb_flux_supervisor;
  logic                    core_clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, saturated = 1'h0, supplyLow = 1'h0;
  logic                    overrangeRaw = 1'h0, degauss_request = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic                    bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0]              wstrb = 4'hF;
  logic [31:0]             awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic signed [15:0]      fluxSample = 16'h0;
  logic                    faultFlagIn, overrangeFlagIn, faultFlagOut, faultFlagOe, overrangeFlagOut;
  logic                    overrangeFlagOe, awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp, rs;
  fss_pkg::bridge_cmd_type bridgeCmd;
  int                      failures = 0, n_compared = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  flux_supervisor #(.DEGAUSS_CYC(20000), .SEARCH_CYC(500), .POWERUP_CYC(50), .MEAS_SHIFT(4)) u_flux_supervisor (.*);
  fss_line_model u_fss_line_model (.faultOe(faultFlagOe), .ovrOe(overrangeFlagOe), .faultLine(faultFlagIn),
    .ovrLine(overrangeFlagIn));
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic waitMode(fss_pkg::bridge_mode_type m, int lim);
    n = 0;
    while (bridgeCmd.mode !== m && n < lim) begin
      tick(1);
      n++;
    end
    chk("mode", 32'(bridgeCmd.mode), 32'(m));
  endtask
  task automatic rst(logic s, logic r);
    sys_rst <= 1'h1;
    saturated <= s;
    degauss_request <= r;
    tick(20);
    sys_rst <= 1'h0;
  endtask
  // Bus read and write, each held until its handshake edge
  task automatic rd(logic [31:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do tick(1); while (!arready);
    arvalid <= 1'h0;
    do tick(1); while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic wr(logic [31:0] a);
    logic aw = 1'h0, w = 1'h0;
    awaddr <= a;
    wdata <= 32'h000000A5;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      tick(1);
      aw |= awvalid & awready;
      w |= wvalid & wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    do tick(1); while (!bvalid);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic ovl(logic signed [15:0] f);
    fluxSample <= f;
    tick(10);
    saturated <= 1'h1;
    fluxSample <= -f;
    waitMode(fss_pkg::BR_OVERRIDE, 900);
    chk("tick", n <= 403, 1'h1);
    chk("sign", bridgeCmd.level[15], f[15]);
    chk("fault", faultFlagOe, 1'h1);
    saturated <= 1'h0;
    fluxSample <= 16'h0;
    waitMode(fss_pkg::BR_LOOP, 900);
    tick(2);
    chk("fault", faultFlagOe, 1'h0);
  endtask
  task automatic degauss();
    degauss_request <= 1'h1;
    tick(2400);
    chk("mode", 32'(bridgeCmd.mode), 32'(fss_pkg::BR_LOOP));
    waitMode(fss_pkg::BR_DEGAUSS, 200);
    chk("level", bridgeCmd.level, 32'h0);
    chk("fault", faultFlagOe, 1'h1);
    tick(20);
    chk("wave", bridgeCmd.level != 16'h0, 1'h1);
    degauss_request <= 1'h0;
    tick(2450);
    chk("mode", 32'(bridgeCmd.mode), 32'(fss_pkg::BR_DEGAUSS));
    waitMode(fss_pkg::BR_LOOP, 100);
    degauss_request <= 1'h1;
    waitMode(fss_pkg::BR_DEGAUSS, 2600);
    waitMode(fss_pkg::BR_LOOP, 20100);
    chk("length", n > 19900, 1'h1);
    degauss_request <= 1'h0;
  endtask
  task automatic flags();
    supplyLow <= 1'h1;
    tick(1990);
    chk("fault", faultFlagOe, 1'h0);
    tick(20);
    chk("fault", faultFlagOe, 1'h1);
    supplyLow <= 1'h0;
    overrangeRaw <= 1'h1;
    tick(290);
    chk("ovr", overrangeFlagOe, 1'h0);
    tick(20);
    chk("ovr", overrangeFlagOe, 1'h1);
    chk("line", faultFlagIn, 1'h0);
    chk("fault", faultFlagOe, 1'h0);
    overrangeRaw <= 1'h0;
  endtask
  task automatic search();
    rst(1'h1, 1'h1);
    waitMode(fss_pkg::BR_RAILS, 5);
    tick(490);
    chk("drive", {bridgeCmd.coilDriveA, bridgeCmd.coilDriveB}, 2'h2);
    tick(20);
    chk("drive", {bridgeCmd.coilDriveA, bridgeCmd.coilDriveB}, 2'h1);
    tick(500);
    rd(32'h4);
    chk("state", {d[13], d[7:0]}, 9'h120);
    rd(32'hC);
    chk("decerr", {rs, 29'h0, |d}, 32'hC0000000);
    wr(32'h10);
    chk("bresp", rs, 2'h3);
    wr(32'h4);
    chk("bresp", rs, 2'h0);
    wr(32'h0);
    rd(32'h0);
    chk("ctrl", d, 32'h1);
    saturated <= 1'h0;
    waitMode(fss_pkg::BR_LOOP, 900);
    rst(1'h1, 1'h0);
    tick(50);
    saturated <= 1'h0;
    waitMode(fss_pkg::BR_LOOP, 500);
  endtask
  // Main sequence
  initial begin
    rst(1'h0, 1'h0);
    tick(10);
    chk("fault", faultFlagOe, 1'h1);
    tick(50);
    chk("fault", faultFlagOe, 1'h0);
    ovl(16'h0400);
    ovl(-16'sh0400);
    degauss();
    flags();
    search();
    rst(1'h0, 1'h1);
    waitMode(fss_pkg::BR_DEGAUSS, 5);
    final_report();
  end
endmodule
bind flux_supervisor flux_supervisor_props u_flux_supervisor_props (.*);
